// ==== icvc_exec.sv ====
`timescale 1ns/100ps
module icvc_exec
   import icvc_pkg::*;
#(
   parameter int         N_IRQ       = 32,
   parameter int         N_VAR       = 256,
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter logic [7:0] HOST_ADDR   = 8'h02
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 arst_n_i,
   input  wire logic [7:0]           rx_byte_i,
   input  wire logic                 rx_valid_i,
   output logic                      rx_ready_o,
   input  wire icvc_cmd_t            prog_cmd_i,
   input  wire logic                 prog_valid_i,
   output logic                      prog_ready_o,
   output logic      [7:0]           tx_byte_o,
   output logic                      tx_valid_o,
   input  wire logic                 tx_ready_i,
   input  wire logic [N_IRQ-1:0]     irq_src_i,
   input  wire icvc_ctx_t            ctx_i,
   output logic                      irq_jump_o,
   output logic      [ICVC_PC_W-1:0] irq_jump_pc_o,
   output logic                      ctx_restore_o,
   output icvc_ctx_t                 ctx_o,
   output logic                      cmp_valid_o,
   output icvc_cmp_t                 cmp_o,
   output logic                      in_handler_o,
   output logic                      irq_global_en_o,
   input  wire logic [7:0]           uvar_idx_i,
   output logic      [31:0]          uvar_data_o
);

   localparam int IRQ_W = (N_IRQ > 1) ? $clog2(N_IRQ) : 1;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SWAP, ST_REPLY} icvc_state_t;

   icvc_state_t                   state_ff;
   icvc_state_t                   nxt_state;
   logic [ICVC_FRAME_LEN-1:0][7:0] rx_buf_ff;
   logic [3:0]                    rx_cnt_ff;
   logic                          rx_full_ff;
   icvc_cmd_t                     cmd_ff;
   logic                          direct_ff;
   logic [ICVC_FRAME_LEN-1:0][7:0] rep_ff;
   logic [3:0]                    tx_cnt_ff;
   logic [N_IRQ-1:0]              irq_en_ff;
   logic [N_IRQ-1:0]              pend_ff;
   logic                          glob_en_ff;
   logic                          in_handler_ff;
   logic [ICVC_PC_W-1:0]          vector_ff [N_IRQ];
   icvc_ctx_t                     saved_ff;
   logic [31:0]                   uvar_ff [N_VAR];
   logic [31:0]                   swap_val_ff;
   icvc_cmd_t                     rx_cmd;
   logic                          rx_mine;
   logic                          take_rx;
   logic                          take_prog;
   logic                          dispatch;
   logic [N_IRQ-1:0]              ready_irq;
   logic [IRQ_W-1:0]              disp_num;
   logic [31:0]                   first_val;
   logic [31:0]                   second_val;
   logic [31:0]                   alu_res;
   logic                          alu_wr;
   logic                          alu_swap;
   logic                          alu_cmp;
   icvc_cmp_t                     alu_flags;
   logic                          exec_calc;
   logic                          tx_fire;

   function automatic logic known_instr(input logic [7:0] ins);
      known_instr = (ins == ICVC_INS_EN) || (ins == ICVC_INS_DIS) ||
                    (ins == ICVC_INS_VECTOR) || (ins == ICVC_INS_RET) ||
                    (ins == ICVC_INS_CALC);
   endfunction

   function automatic logic irq_in_range(input logic [7:0] num);
      irq_in_range = (32'(num) < N_IRQ);
   endfunction

   // Lowest number wins when several sources are ready together
   function automatic logic [IRQ_W-1:0] lowest_set(input logic [N_IRQ-1:0] vec);
      lowest_set = '0;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (vec[i]) begin
            lowest_set = IRQ_W'(i);
         end
      end
   endfunction

   // Frame fields, address first, value most significant first
   assign rx_cmd.instr = rx_buf_ff[7];
   assign rx_cmd.typ   = rx_buf_ff[6];
   assign rx_cmd.bank  = rx_buf_ff[5];
   assign rx_cmd.value = {rx_buf_ff[4], rx_buf_ff[3], rx_buf_ff[2], rx_buf_ff[1]};
   assign rx_mine      = (rx_buf_ff[8] == MODULE_ADDR) && known_instr(rx_cmd.instr);

   assign rx_ready_o   = ~rx_full_ff;
   assign take_rx      = (state_ff == ST_IDLE) && rx_full_ff && rx_mine;
   assign take_prog    = (state_ff == ST_IDLE) && ~rx_full_ff && prog_valid_i;
   assign prog_ready_o = (state_ff == ST_IDLE) && ~rx_full_ff;

   assign ready_irq = pend_ff & irq_en_ff;
   assign disp_num  = lowest_set(ready_irq);
   // Dispatch only between instructions and never inside a handler
   assign dispatch  = (state_ff == ST_IDLE) && ~rx_full_ff && ~prog_valid_i &&
                      glob_en_ff && ~in_handler_ff && (|ready_irq);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_buf_ff  <= '0;
         rx_cnt_ff  <= '0;
         rx_full_ff <= 1'b0;
      end else if (rx_full_ff) begin
         if (state_ff == ST_IDLE) begin
            rx_full_ff <= 1'b0;
         end
      end else if (rx_valid_i) begin
         rx_buf_ff <= {rx_buf_ff[ICVC_FRAME_LEN-2:0], rx_byte_i};
         if (rx_cnt_ff == ICVC_CNT_LAST) begin
            rx_cnt_ff  <= '0;
            rx_full_ff <= 1'b1;
         end else begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
         end
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (take_rx || take_prog) begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (exec_calc && alu_swap) begin
               nxt_state = ST_SWAP;
            end else if (direct_ff) begin
               nxt_state = ST_REPLY;
            end else begin
               nxt_state = ST_IDLE;
            end
         end
         ST_SWAP:  nxt_state = direct_ff ? ST_REPLY : ST_IDLE;
         ST_REPLY: begin
            if (tx_fire && tx_cnt_ff == ICVC_CNT_LAST) begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_ff    <= '0;
         direct_ff <= 1'b0;
      end else if (take_rx) begin
         cmd_ff    <= rx_cmd;
         direct_ff <= 1'b1;
      end else if (take_prog) begin
         cmd_ff    <= prog_cmd_i;
         direct_ff <= 1'b0;
      end
   end

   // Reply value carries no defined content, so it is sent as zero
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rep_ff    <= '0;
         tx_cnt_ff <= '0;
      end else if (state_ff == ST_EXEC) begin
         rep_ff    <= {HOST_ADDR, MODULE_ADDR, ICVC_STATUS_OK, cmd_ff.instr,
                       32'h0000_0000,
                       8'(HOST_ADDR + MODULE_ADDR + ICVC_STATUS_OK + cmd_ff.instr)};
         tx_cnt_ff <= '0;
      end else if (tx_fire) begin
         rep_ff    <= {rep_ff[ICVC_FRAME_LEN-2:0], 8'h00};
         tx_cnt_ff <= tx_cnt_ff + 4'h1;
      end
   end

   assign tx_valid_o = (state_ff == ST_REPLY);
   assign tx_byte_o  = rep_ff[ICVC_FRAME_LEN-1];
   assign tx_fire    = tx_valid_o && tx_ready_i;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_en_ff  <= '0;
         glob_en_ff <= 1'b0;
      end else if (state_ff == ST_EXEC) begin
         if (cmd_ff.instr == ICVC_INS_EN) begin
            if (cmd_ff.typ == ICVC_IRQ_GLOBAL) begin
               glob_en_ff <= 1'b1;
            end else if (irq_in_range(cmd_ff.typ)) begin
               irq_en_ff[cmd_ff.typ[IRQ_W-1:0]] <= 1'b1;
            end
         end else if (cmd_ff.instr == ICVC_INS_DIS) begin
            if (cmd_ff.typ == ICVC_IRQ_GLOBAL) begin
               glob_en_ff <= 1'b0;
            end else if (irq_in_range(cmd_ff.typ)) begin
               irq_en_ff[cmd_ff.typ[IRQ_W-1:0]] <= 1'b0;
            end
         end
      end
   end

   // A source event in the dispatch cycle survives the clear
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_ff <= '0;
      end else begin
         for (int i = 0; i < N_IRQ; i++) begin
            if (irq_src_i[i]) begin
               pend_ff[i] <= 1'b1;
            end else if (dispatch && disp_num == IRQ_W'(i)) begin
               pend_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < N_IRQ; i++) begin
            vector_ff[i] <= '0;
         end
      end else if (state_ff == ST_EXEC && cmd_ff.instr == ICVC_INS_VECTOR &&
                   irq_in_range(cmd_ff.typ)) begin
         vector_ff[cmd_ff.typ[IRQ_W-1:0]] <= cmd_ff.value[ICVC_PC_W-1:0];
      end
   end

   // Return with no handler running is a harmless no-op
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_handler_ff <= 1'b0;
         saved_ff      <= '0;
         irq_jump_o    <= 1'b0;
         irq_jump_pc_o <= '0;
         ctx_restore_o <= 1'b0;
         ctx_o         <= '0;
      end else begin
         irq_jump_o    <= 1'b0;
         ctx_restore_o <= 1'b0;
         if (dispatch) begin
            saved_ff      <= ctx_i;
            in_handler_ff <= 1'b1;
            irq_jump_o    <= 1'b1;
            irq_jump_pc_o <= vector_ff[disp_num];
            // Saved copy shown at once so the program can inspect it
            ctx_o         <= ctx_i;
         end else if (state_ff == ST_EXEC && cmd_ff.instr == ICVC_INS_RET &&
                      in_handler_ff) begin
            in_handler_ff <= 1'b0;
            ctx_restore_o <= 1'b1;
            ctx_o         <= saved_ff;
         end
      end
   end

   assign in_handler_o    = in_handler_ff;
   assign irq_global_en_o = glob_en_ff;

   // Out-of-table codes must not reach the swap step either
   assign exec_calc  = (state_ff == ST_EXEC) && (cmd_ff.instr == ICVC_INS_CALC) &&
                       (cmd_ff.typ[7:4] == 4'h0);
   assign first_val  = uvar_ff[cmd_ff.bank];
   assign second_val = uvar_ff[cmd_ff.value[7:0]];

   icvc_alu u_alu (
      .op_i     (cmd_ff.typ[3:0]),
      .first_i  (first_val),
      .second_i (second_val),
      .res_o    (alu_res),
      .wr_o     (alu_wr),
      .swap_o   (alu_swap),
      .cmp_o    (alu_cmp),
      .flags_o  (alu_flags)
   );

   // Type codes above the table are ignored; accumulator and X stay outside
   // Cleared at reset so calculations never start from unknown words
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < N_VAR; i++) begin
            uvar_ff[i] <= '0;
         end
      end else if (exec_calc && alu_wr && cmd_ff.typ[7:4] == 4'h0) begin
         uvar_ff[cmd_ff.bank] <= alu_res;
      end else if (state_ff == ST_SWAP) begin
         uvar_ff[cmd_ff.value[7:0]] <= swap_val_ff;
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         swap_val_ff <= '0;
         cmp_valid_o <= 1'b0;
         cmp_o       <= '0;
         uvar_data_o <= '0;
      end else begin
         cmp_valid_o <= exec_calc && alu_cmp && cmd_ff.typ[7:4] == 4'h0;
         uvar_data_o <= uvar_ff[uvar_idx_i];
         if (exec_calc) begin
            swap_val_ff <= first_val;
            cmp_o       <= alu_flags;
         end
      end
   end

endmodule // icvc_exec

// ==== icvc_pkg.sv ====
// Operation
// - Code 25 enables interrupt; 255 global
// - Code 26 disables interrupt; 255 global
// - Code 37 stores handler address per interrupt
// - Later vector definition replaces earlier one
// - Code 38 ends handler, resumes program
// - Return restores accumulator, X, flags, PC
// - Code 40: op, first, second index fields
// - Result goes to first user variable
// - Ops 0-4: add, sub, mul, div, mod
// - Ops 5-8: and, or, xor, invert second
// - Ops 9-11: copy, exchange, compare
// - Direct mode replies status 100 success
// - Command frame nine bytes, value MSB first
// - Reply frame nine bytes, status 64 hex
// - Enable acts on one selected source, or on the global switch with 255
package icvc_pkg;

   localparam int          ICVC_PC_W       = 16;
   localparam int          ICVC_X_NUM      = 4;
   localparam int          ICVC_FRAME_LEN  = 9;

   localparam logic [7:0]  ICVC_INS_EN     = 8'h19;
   localparam logic [7:0]  ICVC_INS_DIS    = 8'h1A;
   localparam logic [7:0]  ICVC_INS_VECTOR = 8'h25;
   localparam logic [7:0]  ICVC_INS_RET    = 8'h26;
   localparam logic [7:0]  ICVC_INS_CALC   = 8'h28;
   localparam logic [7:0]  ICVC_IRQ_GLOBAL = 8'hFF;
   localparam logic [7:0]  ICVC_STATUS_OK  = 8'h64;
   localparam logic [3:0]  ICVC_CNT_LAST   = 4'h8;

   localparam logic [3:0]  ICVC_OP_ADD     = 4'h0;
   localparam logic [3:0]  ICVC_OP_SUB     = 4'h1;
   localparam logic [3:0]  ICVC_OP_MUL     = 4'h2;
   localparam logic [3:0]  ICVC_OP_DIV     = 4'h3;
   localparam logic [3:0]  ICVC_OP_MOD     = 4'h4;
   localparam logic [3:0]  ICVC_OP_AND     = 4'h5;
   localparam logic [3:0]  ICVC_OP_OR      = 4'h6;
   localparam logic [3:0]  ICVC_OP_XOR     = 4'h7;
   localparam logic [3:0]  ICVC_OP_NOT     = 4'h8;
   localparam logic [3:0]  ICVC_OP_LOAD    = 4'h9;
   localparam logic [3:0]  ICVC_OP_SWAP    = 4'hA;
   localparam logic [3:0]  ICVC_OP_COMP    = 4'hB;

   typedef struct packed {
      logic [7:0]  instr;
      logic [7:0]  typ;
      logic [7:0]  bank;
      logic [31:0] value;
   } icvc_cmd_t;

   typedef struct packed {
      logic [31:0]                  acc;
      logic [ICVC_X_NUM-1:0][31:0]  xreg;
      logic [7:0]                   flags;
      logic [ICVC_PC_W-1:0]         pc;
   } icvc_ctx_t;

   typedef struct packed {
      logic zero;
      logic less;
   } icvc_cmp_t;

endpackage

// ==== icvc_alu.sv ====
`timescale 1ns/100ps
module icvc_alu
   import icvc_pkg::*;
(
   input  wire logic [3:0]  op_i,
   input  wire logic [31:0] first_i,
   input  wire logic [31:0] second_i,
   output logic      [31:0] res_o,
   output logic             wr_o,
   output logic             swap_o,
   output logic             cmp_o,
   output icvc_cmp_t        flags_o
);

   logic signed [31:0] a;
   logic signed [31:0] b;
   logic signed [63:0] prod;

   assign a    = first_i;
   assign b    = second_i;
   assign prod = a * b;

   always_comb begin
      res_o  = first_i;
      wr_o   = 1'b1;
      swap_o = 1'b0;
      cmp_o  = 1'b0;
      unique case (op_i)
         ICVC_OP_ADD:  res_o = first_i + second_i;
         ICVC_OP_SUB:  res_o = first_i - second_i;
         ICVC_OP_MUL:  res_o = prod[31:0];
         // Zero divisor leaves the variable unchanged rather than trapping
         ICVC_OP_DIV: begin
            wr_o  = (a != 32'sh0);
            res_o = (a != 32'sh0) ? 32'(b / a) : first_i;
         end
         ICVC_OP_MOD: begin
            wr_o  = (a != 32'sh0);
            res_o = (a != 32'sh0) ? 32'(b % a) : first_i;
         end
         ICVC_OP_AND:  res_o = first_i & second_i;
         ICVC_OP_OR:   res_o = first_i | second_i;
         ICVC_OP_XOR:  res_o = first_i ^ second_i;
         ICVC_OP_NOT:  res_o = ~second_i;
         ICVC_OP_LOAD: res_o = second_i;
         ICVC_OP_SWAP: begin
            res_o  = second_i;
            swap_o = 1'b1;
         end
         ICVC_OP_COMP: begin
            wr_o  = 1'b0;
            cmp_o = 1'b1;
         end
         default:      wr_o = 1'b0;
      endcase
   end

   assign flags_o.zero = (first_i == second_i);
   assign flags_o.less = (a < b);

endmodule // icvc_alu

// ==== icvc_exec_sva.sv ====
`timescale 1ns/100ps
module icvc_exec_sva
   import icvc_pkg::*;
#(
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   input  wire logic       rx_valid_i,
   input  wire logic       rx_ready_o,
   input  wire logic [7:0] tx_byte_o,
   input  wire logic       tx_valid_o,
   input  wire logic       tx_ready_i,
   input  wire icvc_ctx_t  ctx_i,
   input  wire logic       irq_jump_o,
   input  wire logic       ctx_restore_o,
   input  wire icvc_ctx_t  ctx_o,
   input  wire logic       cmp_valid_o,
   input  wire logic       in_handler_o,
   input  wire logic       irq_global_en_o
);
   logic [3:0] rx_cnt_ff;
   logic [3:0] tx_cnt_ff;

   default clocking dcb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   // Counts assume aligned frames; a lost byte would confuse them
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         rx_cnt_ff <= 4'h0;
      else if (rx_valid_i && rx_ready_o)
         rx_cnt_ff <= (rx_cnt_ff == ICVC_CNT_LAST) ? 4'h0 : rx_cnt_ff + 4'h1;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i)
         tx_cnt_ff <= 4'h0;
      else if (tx_valid_o && tx_ready_i)
         tx_cnt_ff <= (tx_cnt_ff == ICVC_CNT_LAST) ? 4'h0 : tx_cnt_ff + 4'h1;
   end

   sequence s_ninth_take;
      rx_valid_i && rx_ready_o && rx_cnt_ff == ICVC_CNT_LAST;
   endsequence

   sequence s_reply_start;
      $rose(tx_valid_o) && tx_cnt_ff == 4'h0;
   endsequence

   chk_frame_stall: assert property (s_ninth_take |=> !rx_ready_o)
      else $error("receiver kept taking after a full frame");
   chk_reply_head: assert property (s_reply_start |-> tx_byte_o == HOST_ADDR)
      else $error("reply does not open with host address");
   chk_reply_status: assert property (tx_valid_o && tx_cnt_ff == 4'h2 |->
      tx_byte_o == ICVC_STATUS_OK) else $error("reply status not success");
   chk_jump_pulse: assert property (irq_jump_o |=> !irq_jump_o)
      else $error("jump pulse longer than one cycle");
   chk_jump_saves_ctx: assert property (irq_jump_o |-> ctx_o == $past(ctx_i))
      else $error("context not saved at dispatch");
   chk_jump_gated: assert property (irq_jump_o |->
      $past(irq_global_en_o) && !$past(in_handler_o)) else $error("dispatch not allowed");
   chk_restore_exit: assert property (ctx_restore_o |->
      !in_handler_o && $past(in_handler_o)) else $error("restore outside handler");
   chk_ctx_held: assert property (!irq_jump_o |-> $stable(ctx_o))
      else $error("saved context changed without dispatch");
   chk_cmp_pulse: assert property (cmp_valid_o |=> !cmp_valid_o)
      else $error("compare pulse longer than one cycle");
endmodule // icvc_exec_sva

bind icvc_exec icvc_exec_sva #(.HOST_ADDR(HOST_ADDR)) u_sva (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i),
   .rx_ready_o(rx_ready_o), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .ctx_i(ctx_i), .irq_jump_o(irq_jump_o),
   .ctx_restore_o(ctx_restore_o), .ctx_o(ctx_o), .cmp_valid_o(cmp_valid_o),
   .in_handler_o(in_handler_o), .irq_global_en_o(irq_global_en_o));

// ==== icvc_host_model.sv ====
`timescale 1ns/100ps
module icvc_host_model (
   input  wire logic       clk_sys_i,
   output logic      [7:0] rx_byte_o,
   output logic            rx_valid_o,
   input  wire logic       rx_ready_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o
);
   logic [7:0] rep_q[$];
   logic       slow = 1'b0;

   initial begin
      rx_byte_o  = 8'h00;
      rx_valid_o = 1'b0;
   end

   // Slow host takes a reply byte only every other cycle
   always @(negedge clk_sys_i) tx_ready_o <= slow ? !tx_ready_o : 1'b1;
   always @(posedge clk_sys_i) if (tx_valid_i && tx_ready_o) rep_q.push_back(tx_byte_i);

   task automatic send(input logic [7:0] addr, ins, typ, bank, input logic [31:0] val);
      logic [7:0] f [9];
      f = '{addr, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) f[8] += f[i];
      for (int i = 0; i < 9; i++) begin
         @(negedge clk_sys_i);
         rx_byte_o  = f[i];
         rx_valid_o = 1'b1;
         while (rx_ready_i !== 1'b1) @(negedge clk_sys_i);
      end
      @(negedge clk_sys_i);
      rx_valid_o = 1'b0;
      // Released line must not look like a stale byte
      rx_byte_o  = ~rx_byte_o;
   endtask
endmodule // icvc_host_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench
   import icvc_pkg::*;
;
   localparam icvc_ctx_t CTX_A = {32'h1234_5678, {4{32'hA5A5_5A5A}}, 8'h3C, 16'h0042};
   localparam icvc_ctx_t CTX_B = ~CTX_A;
   logic                 clk_sys_i = 1'b0;
   logic                 arst_n_i = 1'b0;
   logic      [7:0]      rx_byte, tx_byte;
   logic                 rx_valid, rx_ready, tx_valid, tx_ready;
   icvc_cmd_t            prog_cmd = '0;
   logic                 prog_valid = 1'b0;
   logic                 prog_ready, irq_jump, ctx_restore, cmp_valid, in_handler, glob_en;
   logic      [31:0]     irq_src = '0;
   icvc_ctx_t            ctx_in = CTX_A;
   icvc_ctx_t            ctx_out, rest_ctx;
   logic      [15:0]     jump_pc;
   logic      [7:0]      uvar_idx = 8'h00;
   logic      [31:0]     uvar_data;
   icvc_cmp_t            cmp_flags;
   int unsigned          bad_count = 0, samples_checked = 0, jumps = 0, restores = 0, cmps = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   icvc_exec i_icvc_exec (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .rx_byte_i(rx_byte),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .prog_cmd_i(prog_cmd),
      .prog_valid_i(prog_valid), .prog_ready_o(prog_ready), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .irq_src_i(irq_src), .ctx_i(ctx_in),
      .irq_jump_o(irq_jump), .irq_jump_pc_o(jump_pc), .ctx_restore_o(ctx_restore),
      .ctx_o(ctx_out), .cmp_valid_o(cmp_valid), .cmp_o(cmp_flags), .in_handler_o(in_handler),
      .irq_global_en_o(glob_en), .uvar_idx_i(uvar_idx), .uvar_data_o(uvar_data));

   icvc_host_model u_host (
      .clk_sys_i(clk_sys_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .rx_ready_i(rx_ready), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready));

   // Pulses are counted at the falling edge, where they have settled
   always @(negedge clk_sys_i) begin
      jumps    <= jumps + (irq_jump === 1'b1);
      cmps     <= cmps + (cmp_valid === 1'b1);
      restores <= restores + (ctx_restore === 1'b1);
      if (ctx_restore === 1'b1) rest_ctx <= ctx_out;
   end

   task automatic check(input logic [199:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t %s: got %0h exp %0h", $time, what, seen, exp);
      end
   endtask

   task automatic final_report;
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic prog(input logic [7:0] ins, typ, input logic [31:0] val);
      @(negedge clk_sys_i);
      prog_cmd   = '{ins, typ, 8'h00, val};
      prog_valid = 1'b1;
      while (prog_ready !== 1'b1) @(negedge clk_sys_i);
      @(negedge clk_sys_i);
      prog_valid = 1'b0;
      repeat (3) @(negedge clk_sys_i);
   endtask

   task automatic fire(input int n, input int unsigned exp_jumps, input string what);
      @(negedge clk_sys_i);
      irq_src[n] = 1'b1;
      @(negedge clk_sys_i);
      irq_src = '0;
      repeat (8) @(negedge clk_sys_i);
      check(jumps, exp_jumps, what);
   endtask

   task automatic reply(input logic [7:0] ins);
      logic [7:0] exp [9];
      exp = '{8'h02, 8'h01, ICVC_STATUS_OK, ins, 8'h00, 8'h00, 8'h00, 8'h00, 8'h67 + ins};
      for (int i = 0; i < 200 && u_host.rep_q.size() < 9; i++) @(negedge clk_sys_i);
      for (int i = 0; i < 9; i++)
         check(u_host.rep_q.size() > 0 ? u_host.rep_q.pop_front() : 8'hXX, exp[i], "reply");
   endtask

   task automatic t_direct;
      logic [7:0]  ins [4] = '{ICVC_INS_EN, ICVC_INS_DIS, ICVC_INS_VECTOR, ICVC_INS_RET};
      // Operation, first index, second index, first afterwards; all start at zero
      logic [51:0] row [14] = '{
         {ICVC_OP_NOT, 8'h01, 8'h00, 32'hFFFF_FFFF}, {ICVC_OP_SUB, 8'h02, 8'h01, 32'h0000_0001},
         {ICVC_OP_ADD, 8'h02, 8'h02, 32'h0000_0002}, {ICVC_OP_SUB, 8'h02, 8'h01, 32'h0000_0003},
         {ICVC_OP_LOAD, 8'h03, 8'h02, 32'h0000_0003}, {ICVC_OP_MUL, 8'h03, 8'h03, 32'h0000_0009},
         {ICVC_OP_ADD, 8'h03, 8'h01, 32'h0000_0008}, {ICVC_OP_SWAP, 8'h02, 8'h03, 32'h0000_0008},
         {ICVC_OP_MOD, 8'h03, 8'h02, 32'h0000_0002}, {ICVC_OP_DIV, 8'h03, 8'h02, 32'h0000_0004},
         {ICVC_OP_OR, 8'h02, 8'h03, 32'h0000_000C}, {ICVC_OP_XOR, 8'h03, 8'h01, 32'hFFFF_FFFB},
         {ICVC_OP_AND, 8'h03, 8'h02, 32'h0000_0008}, {ICVC_OP_COMP, 8'h03, 8'h02, 32'h0000_0008}};
      for (int i = 0; i < 4; i++) begin
         u_host.send(8'h01, ins[i], 8'h07, 8'h00, 32'h0000_0050);
         reply(ins[i]);
      end
      check(restores, 0, "return without handler");
      u_host.slow = 1'b1;
      for (int i = 0; i < 14; i++) begin
         u_host.send(8'h01, ICVC_INS_CALC, {4'h0, row[i][51:48]}, row[i][47:40],
                     {24'h00_0000, row[i][39:32]});
         reply(ICVC_INS_CALC);
         uvar_idx = row[i][47:40];
         @(negedge clk_sys_i);
         check(uvar_data, row[i][31:0], "calc result");
      end
      u_host.slow = 1'b0;
      check(cmps, 1, "compare pulse");
      check(cmp_flags, 2'b01, "compare flags");
      u_host.send(8'h03, ICVC_INS_EN, 8'h07, 8'h00, 32'h0);
      u_host.send(8'h01, 8'h21, 8'h07, 8'h00, 32'h0);
      repeat (30) @(negedge clk_sys_i);
      check(u_host.rep_q.size(), 0, "refused frames");
   endtask

   task automatic t_irq;
      prog(ICVC_INS_VECTOR, 8'h03, 32'h0000_0100);
      prog(ICVC_INS_VECTOR, 8'h03, 32'h0000_0123);
      prog(ICVC_INS_VECTOR, 8'h04, 32'h0000_0200);
      prog(ICVC_INS_EN, 8'h03, 32'h0);
      prog(ICVC_INS_EN, ICVC_IRQ_GLOBAL, 32'h0);
      check(glob_en, 1'b1, "global on");
      fire(4, 0, "source 4 not enabled");
      fire(3, 1, "dispatch");
      check(jump_pc, 16'h0123, "vector");
      check(ctx_out, CTX_A, "saved context");
      check(in_handler, 1'b1, "in handler");
      ctx_in = CTX_B;
      fire(3, 1, "nested dispatch");
      prog(ICVC_INS_RET, 8'h00, 32'h0);
      repeat (8) @(negedge clk_sys_i);
      check(restores, 1, "restore pulse");
      check(rest_ctx, CTX_A, "restored context");
      check(jumps, 2, "pending after return");
      check(ctx_out, CTX_B, "second save");
      prog(ICVC_INS_RET, 8'h00, 32'h0);
      prog(ICVC_INS_DIS, 8'h03, 32'h0);
      fire(3, 2, "source disabled");
      prog(ICVC_INS_DIS, ICVC_IRQ_GLOBAL, 32'h0);
      check(glob_en, 1'b0, "global off");
      prog(ICVC_INS_EN, 8'h03, 32'h0);
      repeat (8) @(negedge clk_sys_i);
      check(jumps, 2, "globally blocked");
      prog(ICVC_INS_EN, ICVC_IRQ_GLOBAL, 32'h0);
      repeat (8) @(negedge clk_sys_i);
      check(jumps, 3, "dispatch after global on");
      prog(ICVC_INS_RET, 8'h00, 32'h0);
      check(in_handler, 1'b0, "handler left");
   endtask

   initial begin
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      t_direct();
      t_irq();
      final_report();
   end

   // Whole run needs under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
endmodule // testbench
